// ### usm_dev_model.sv
// usm_dev_model: the sixteen device uart ends facing the switch matrix
// assumes the bench gives the pattern that each powered device sends
`timescale 1ns/1ps
`default_nettype none
module usm_dev_model (
    // supply seen by each device
    input  wire logic [15:0] dev_supply_en,
    // pattern sent by a powered device
    input  wire logic [15:0] tx_pat,
    // device tx pins
    output logic      [15:0] dev_tx
);
    // an unpowered device holds nothing, so show the inverse and not a stale level
    assign dev_tx = (tx_pat & dev_supply_en) | (~tx_pat & ~dev_supply_en);
endmodule
`default_nettype wire

// ### usm_pkg.sv
// usm_pkg: shared constants for the uart switch matrix
// assumes a single 125 MHz reference clock
package usm_pkg;
    localparam int unsigned CHANNELS      = 16;
    localparam int unsigned CLK_MHZ       = 125;
    localparam int unsigned PULSE_SHORT_MS = 300;
    localparam int unsigned PULSE_LONG_MS  = 500;
    localparam int unsigned CYC_PER_MS    = CLK_MHZ * 1000;
    localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_MS * CYC_PER_MS;
    localparam int unsigned PULSE_LONG_CYC  = PULSE_LONG_MS * CYC_PER_MS;
    localparam int unsigned CNT_W         = 27;
    localparam logic [1:0]  MODE_OFF      = 2'h0;
    localparam logic [1:0]  MODE_NORMAL   = 2'h1;
    localparam logic [1:0]  MODE_TRIM     = 2'h2;
    localparam logic [1:0]  MODE_LOOP     = 2'h3;
    localparam logic        IDLE_LEVEL    = 1'h1;
    localparam logic        RST_N_INACT   = 1'h1;
    typedef enum logic [1:0] {USM_P_IDLE, USM_P_RUN} usm_pstate_t;
endpackage

// ### usm_switch_matrix.sv
// usm_switch_matrix: uart routing, supply switching, device reset and calibration pulse
// assumes controller writes arrive synchronous to ref_clk; uart pins pass combinationally
`timescale 1ns/1ps
`default_nettype none
module usm_switch_matrix #(
    parameter int unsigned N         = usm_pkg::CHANNELS,
    parameter int unsigned SHORT_CYC = usm_pkg::PULSE_SHORT_CYC,
    parameter int unsigned LONG_CYC  = usm_pkg::PULSE_LONG_CYC
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // controller write port
    input  wire logic         cmd_we,
    input  wire logic [3:0]   cmd_chan,
    input  wire logic [1:0]   cmd_mode,
    input  wire logic         cmd_supply,
    input  wire logic         cmd_prog_supply,
    input  wire logic         cmd_reset,
    input  wire logic         pulse_start,
    input  wire logic         pulse_long,
    // status
    output logic              pulse_busy,
    // host side uart
    input  wire logic [N-1:0] host_tx,
    output logic [N-1:0]      host_rx,
    // device side
    input  wire logic [N-1:0] dev_tx,
    output logic [N-1:0]      dev_rx,
    output logic [N-1:0]      dev_cal_pulse,
    output logic [N-1:0]      dev_supply_en,
    output logic [N-1:0]      dev_prog_en,
    output logic [N-1:0]      dev_rst_n
);
    logic [1:0]   mode_q [N];
    logic [1:0]   mode_d [N];
    logic [N-1:0] sup_q, sup_d, prog_q, prog_d, rst_q, rst_d;
    usm_pkg::usm_pstate_t ps_q, ps_d;
    logic [usm_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic         pulse_q, pulse_d;

    // one register group per control plane; channels written one at a time
    always_comb begin
        for (int i = 0; i < N; i++) begin
            mode_d[i] = mode_q[i];
        end
        sup_d  = sup_q;
        prog_d = prog_q;
        rst_d  = rst_q;
        if (cmd_we) begin
            mode_d[cmd_chan] = cmd_mode;
            sup_d[cmd_chan]  = cmd_supply;
            prog_d[cmd_chan] = cmd_prog_supply;
            rst_d[cmd_chan]  = cmd_reset;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                mode_q[i] <= usm_pkg::MODE_OFF;
            end
            sup_q  <= '0;
            prog_q <= '0;
            rst_q  <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                mode_q[i] <= mode_d[i];
            end
            sup_q  <= sup_d;
            prog_q <= prog_d;
            rst_q  <= rst_d;
        end
    end

    // pulse timer shared by all channels, so every trimmed device sees the same edge
    always_comb begin
        ps_d    = ps_q;
        cnt_d   = cnt_q;
        pulse_d = pulse_q;
        unique case (ps_q)
            usm_pkg::USM_P_IDLE: begin
                pulse_d = 1'h0;
                if (pulse_start) begin
                    ps_d    = usm_pkg::USM_P_RUN;
                    cnt_d   = pulse_long ? usm_pkg::CNT_W'(LONG_CYC - 1) : usm_pkg::CNT_W'(SHORT_CYC - 1);
                    pulse_d = 1'h1;
                end
            end
            usm_pkg::USM_P_RUN: begin
                if (cnt_q == '0) begin
                    ps_d    = usm_pkg::USM_P_IDLE;
                    pulse_d = 1'h0;
                end else begin
                    cnt_d = cnt_q - 1'h1;
                end
            end
            default: begin
                ps_d    = usm_pkg::USM_P_IDLE;
                pulse_d = 1'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ps_q    <= usm_pkg::USM_P_IDLE;
            cnt_q   <= '0;
            pulse_q <= 1'h0;
        end else begin
            ps_q    <= ps_d;
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_busy = pulse_q;

    // watch-only: length of the running pulse and the length chosen when it started
    logic [usm_pkg::CNT_W-1:0] len_q, len_d;
    logic                      sel_long_q, sel_long_d;

    always_comb begin
        len_d      = pulse_q ? len_q + 1'h1 : '0;
        sel_long_d = (!pulse_q && pulse_start) ? pulse_long : sel_long_q;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            len_q      <= '0;
            sel_long_q <= 1'h0;
        end else begin
            len_q      <= len_d;
            sel_long_q <= sel_long_d;
        end
    end

    // routing is combinational so uart bit timing is untouched by the clock
    always_comb begin
        for (int i = 0; i < N; i++) begin
            host_rx[i]       = usm_pkg::IDLE_LEVEL;
            dev_rx[i]        = usm_pkg::IDLE_LEVEL;
            dev_cal_pulse[i] = 1'h0;
            if (sup_q[i]) begin
                unique case (mode_q[i])
                    usm_pkg::MODE_NORMAL: begin
                        dev_rx[i]  = host_tx[i];
                        host_rx[i] = dev_tx[i];
                    end
                    usm_pkg::MODE_TRIM: begin
                        dev_rx[i]        = pulse_q;
                        dev_cal_pulse[i] = pulse_q;
                        host_rx[i]       = dev_tx[i];
                    end
                    usm_pkg::MODE_LOOP: begin
                        host_rx[i] = host_tx[i];
                    end
                    usm_pkg::MODE_OFF: begin
                        host_rx[i] = usm_pkg::IDLE_LEVEL;
                    end
                endcase
            end
        end
    end

    assign dev_supply_en = sup_q;
    assign dev_prog_en   = prog_q & sup_q;
    assign dev_rst_n     = ~rst_q;

    property p_prog_gate;
        @(posedge ref_clk) disable iff (!rstn) (cmd_we && !cmd_supply) |=> !dev_prog_en[$past(cmd_chan)];
    endproperty
    a_prog_gate: assert property (p_prog_gate) else $error("prog supply on without device supply");

    property p_cut_when_off;
        @(posedge ref_clk) disable iff (!rstn) !(|(~sup_q & (~host_rx | ~dev_rx | dev_cal_pulse)));
    endproperty
    a_cut_when_off: assert property (p_cut_when_off) else $error("uart not cut with supply off");

    property p_supply_write;
        @(posedge ref_clk) disable iff (!rstn) cmd_we |=> dev_supply_en[$past(cmd_chan)] == $past(cmd_supply);
    endproperty
    a_supply_write: assert property (p_supply_write) else $error("supply write not applied");

    property p_reset_write;
        @(posedge ref_clk) disable iff (!rstn) cmd_we |=> dev_rst_n[$past(cmd_chan)] == !$past(cmd_reset);
    endproperty
    a_reset_write: assert property (p_reset_write) else $error("reset write not applied");

    property p_pulse_rise;
        @(posedge ref_clk) disable iff (!rstn) (!pulse_q && pulse_start) |=> pulse_q;
    endproperty
    a_pulse_rise: assert property (p_pulse_rise) else $error("pulse did not start");

    property p_pulse_hold;
        @(posedge ref_clk) disable iff (!rstn) $rose(pulse_q) |-> pulse_q [*8];
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended too early");

    // counted independently of the down counter, so a wrong reload or a restart shows up
    property p_pulse_len;
        @(posedge ref_clk) disable iff (!rstn) $fell(pulse_q)
            |-> len_q == (sel_long_q ? usm_pkg::CNT_W'(LONG_CYC) : usm_pkg::CNT_W'(SHORT_CYC));
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length differs from selection");

    // every channel is watched, since the bench exercises modes on scattered channels
    for (genvar g = 0; g < N; g++) begin : g_route_chk
        property p_normal_route;
            @(posedge ref_clk) disable iff (!rstn) (sup_q[g] && mode_q[g] == usm_pkg::MODE_NORMAL)
                |-> dev_rx[g] == host_tx[g] && host_rx[g] == dev_tx[g];
        endproperty
        a_normal_route: assert property (p_normal_route) else $error("normal route broken");

        property p_trim_route;
            @(posedge ref_clk) disable iff (!rstn) (sup_q[g] && mode_q[g] == usm_pkg::MODE_TRIM)
                |-> dev_rx[g] == pulse_busy && dev_cal_pulse[g] == pulse_busy && host_rx[g] == dev_tx[g];
        endproperty
        a_trim_route: assert property (p_trim_route) else $error("trim route broken");

        property p_loop_route;
            @(posedge ref_clk) disable iff (!rstn) (sup_q[g] && mode_q[g] == usm_pkg::MODE_LOOP)
                |-> host_rx[g] == host_tx[g] && dev_rx[g];
        endproperty
        a_loop_route: assert property (p_loop_route) else $error("loopback route broken");
    end
endmodule
`default_nettype wire

// ### usm_switch_matrix_tb.sv
// usm_switch_matrix_tb: directed tests of routing, supplies, reset and pulse
// assumes short pulse counts set by parameter; inputs change at falling edge
`timescale 1ns/1ps
`default_nettype none
module usm_switch_matrix_tb;
    localparam int SHORT = 20;
    localparam int LONG  = 30;
    logic        ref_clk, rstn, cmd_we, cmd_supply, cmd_prog_supply, cmd_reset;
    logic        pulse_start, pulse_long, pulse_busy;
    logic [3:0]  cmd_chan;
    logic [1:0]  cmd_mode;
    logic [15:0] host_tx, host_rx, dev_tx, dev_rx, dev_cal_pulse, dev_supply_en, dev_prog_en, dev_rst_n, tx_pat;
    int          failures, check_count;

    usm_switch_matrix #(.N(16), .SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
        .cmd_we(cmd_we), .cmd_chan(cmd_chan), .cmd_mode(cmd_mode), .cmd_supply(cmd_supply),
        .cmd_prog_supply(cmd_prog_supply), .cmd_reset(cmd_reset), .pulse_start(pulse_start),
        .pulse_long(pulse_long), .pulse_busy(pulse_busy), .host_tx(host_tx), .host_rx(host_rx),
        .dev_tx(dev_tx), .dev_rx(dev_rx), .dev_cal_pulse(dev_cal_pulse), .dev_supply_en(dev_supply_en),
        .dev_prog_en(dev_prog_en), .dev_rst_n(dev_rst_n));
    usm_dev_model model_u (.dev_supply_en(dev_supply_en), .tx_pat(tx_pat), .dev_tx(dev_tx));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ch, input logic [1:0] md, input logic s, input logic p, input logic r);
        @(negedge ref_clk);
        cmd_we = 1'h1;
        cmd_chan = ch;
        cmd_mode = md;
        cmd_supply = s;
        cmd_prog_supply = p;
        cmd_reset = r;
        @(negedge ref_clk);
        cmd_we = 1'h0;
    endtask
    // a second start held during the pulse must not stretch or restart it
    task automatic pulse(input logic lng, input int exp);
        int n;
        n = 0;
        @(negedge ref_clk);
        pulse_start = 1'h1;
        pulse_long = lng;
        @(negedge ref_clk);
        pulse_long = ~lng;
        while (pulse_busy === 1'h1 && n < 100) begin
            n++;
            chk(dev_cal_pulse, 16'h0080, "cal pulse");
            chk(dev_rx, 16'hFFFF, "trim rx pulse");
            @(negedge ref_clk);
            pulse_start = 1'h0;
        end
        chk(n[15:0], exp[15:0], "pulse length");
        chk(dev_cal_pulse, 16'h0000, "cal pulse end");
        chk(dev_rx, 16'hFF7F, "trim rx after pulse");
        $display("test pulse done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #(5000 * 8);
        failures++;
        test_done();
    end
    initial begin
        {rstn, cmd_we, cmd_chan, cmd_mode, cmd_supply, cmd_prog_supply, cmd_reset, pulse_start, pulse_long} = '0;
        host_tx = 16'hA5C3;
        tx_pat = 16'h3C5A;
        repeat (3) @(negedge ref_clk);
        rstn = 1'h1;
        chk(dev_supply_en | dev_prog_en, 16'h0000, "supplies after reset");
        chk(dev_rst_n & host_rx & dev_rx, 16'hFFFF, "idle after reset");
        $display("test reset done");
        wr(4'h3, usm_pkg::MODE_NORMAL, 1'h1, 1'h1, 1'h0);
        wr(4'h4, usm_pkg::MODE_NORMAL, 1'h0, 1'h1, 1'h0);
        chk(dev_supply_en, 16'h0008, "supply");
        chk(dev_prog_en, 16'h0008, "prog gated");
        for (int k = 0; k < 2; k++) begin
            @(negedge ref_clk);
            host_tx = ~host_tx;
            tx_pat = ~tx_pat;
            #1;
            chk(dev_rx, (host_tx & 16'h0008) | 16'hFFF7, "normal rx");
            chk(host_rx, (tx_pat & 16'h0008) | 16'hFFF7, "normal tx, ch4 cut");
        end
        wr(4'h3, usm_pkg::MODE_NORMAL, 1'h0, 1'h1, 1'h0);
        chk(dev_rx & host_rx, 16'hFFFF, "cut without supply");
        chk(dev_prog_en, 16'h0000, "prog off");
        wr(4'h9, usm_pkg::MODE_NORMAL, 1'h1, 1'h0, 1'h1);
        chk(dev_rst_n, 16'hFDFF, "reset out");
        wr(4'h9, usm_pkg::MODE_OFF, 1'h1, 1'h0, 1'h0);
        chk(dev_rst_n & dev_rx, 16'hFFFF, "reset release");
        wr(4'h5, usm_pkg::MODE_LOOP, 1'h1, 1'h0, 1'h0);
        wr(4'h7, usm_pkg::MODE_TRIM, 1'h1, 1'h0, 1'h0);
        chk(host_rx, (host_tx & 16'h0020) | (tx_pat & 16'h0080) | 16'hFF5F, "loop and trim");
        chk(dev_supply_en, 16'h02A0, "parallel supplies");
        $display("test routing done");
        pulse(1'h0, SHORT);
        pulse(1'h1, LONG);
        chk(host_rx, (host_tx & 16'h0020) | (tx_pat & 16'h0080) | 16'hFF5F, "trim tx kept");
        wr(4'hA, usm_pkg::MODE_NORMAL, 1'h1, 1'h1, 1'h1);
        chk(dev_rst_n, 16'hFBFF, "reset out before mid reset");
        @(negedge ref_clk);
        rstn = 1'h0;
        #1;
        chk(dev_supply_en | dev_prog_en | dev_cal_pulse | {15'h0, pulse_busy}, 16'h0000, "mid reset outputs");
        chk(dev_rst_n & host_rx & dev_rx, 16'hFFFF, "idle in mid reset");
        @(negedge ref_clk);
        rstn = 1'h1;
        repeat (2) @(negedge ref_clk);
        chk(dev_supply_en | dev_prog_en, 16'h0000, "no supply before command");
        $display("test mid reset done");
        test_done();
    end
endmodule
`default_nettype wire
